// ### bench/arpwm_asserts.sv
`timescale 1ns/1ns
// Watches the register bus and the pin of the timer from its ports.
module arpwm_chk (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin.
  input wire logic pulse_output,
  input wire logic output_pin_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Request steps of the read and write directions.
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_aw_busy: assert property (wr_take |=> !s_axi_awready)
    else $error("address taken while busy");
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_rsvd_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_pin_free: assert property (
    !output_pin_enable && !$past(output_pin_enable) |-> !pulse_output)
    else $error("pin driven while free");
endmodule

bind autoreload_pwm_timer arpwm_chk chk_u (.*);

// ### bench/autoreload_pwm_timer_bench.sv
`timescale 1ns/1ns
// Drives the timer over its register bus and checks reads and the pin.
module autoreload_pwm_timer_bench;
  import arpwm_pkg::*;
  // Inputs driven by the bench, all set at time zero.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic lite_timebase_clock = 1'b0;
  // Outputs of the design.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pulse_output, output_pin_enable;
  logic overflow_irq, compare_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Scoreboard state.
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'ha463f461;
  int n;
  int m;
  logic [9:0] exp_q[$];

  autoreload_pwm_timer dut_u (.*);

  // Clock of 20 ns period.
  always #10 aclk = ~aclk;

  // Cuts a hang short.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  // Compares each read answer with the oldest note.
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk("rdata", {s_axi_rresp, s_axi_rdata[7:0]}, exp_q.pop_front());
    end
  end

  // Compares a seen value with the expected one.
  task automatic chk(input string nm, input logic [9:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  // Holds reset low for 20 cycles.
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Writes one register word; noise in the unused data bits.
  task automatic wr(input logic [7:0] a, d, input logic [1:0] e = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {a[5:0], 2'b00};
    s_axi_wdata <= {24'($random(seed)), d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 10'(s_axi_bresp), 10'(e));
  endtask

  // Reads one register word and notes the expected answer.
  task automatic rd(input logic [7:0] a, d, input logic [1:0] e = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {a[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    exp_q.push_back({e, d});
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Writes a register and reads it back.
  task automatic wrd(input logic [7:0] a, d, r);
    wr(a, d);
    rd(a, r);
  endtask

  // Counts pin-high cycles over a window.
  task automatic hi_count(output int c);
    c = 0;
    repeat (32) begin
      @(posedge aclk);
      if (pulse_output === 1'b1) c++;
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    do_reset();
    // Reset values, unmapped words in the gap answer with an error.
    for (n = 13; n < 25; n++) begin
      rd(8'(n), 8'h00, (n > 19 && n < 23) ? RESP_SLVERR : RESP_OKAY);
    end
    wr(8'h14, 8'hff, RESP_SLVERR);
    // A write without the low byte lane leaves the register alone.
    s_axi_wstrb <= 4'he;
    wr(8'h12, 8'h01);
    s_axi_wstrb <= 4'hf;
    rd(8'h12, 8'h00);
    // Reserved and read-only bits, reload of ff0.
    wrd(8'h0d, 8'he4, 8'h00);
    wrd(8'h10, 8'hff, 8'h0f);
    wrd(8'h11, 8'hf0, 8'hf0);
    wrd(8'h12, 8'hfe, 8'h00);
    wrd(8'h13, 8'hfe, 8'h02);
    wrd(8'h0f, 8'hff, 8'h00);
    wrd(8'h17, 8'hf0, 8'h00);
    // Overflow on the processor clock, then stopped.
    wr(8'h0d, 8'h12);
    while (overflow_irq !== 1'b1) @(posedge aclk);
    wr(8'h0d, 8'h02);
    // Five more ticks pass after the reload before the stop lands.
    rd(8'h0f, 8'hf5);
    rd(8'h0e, 8'h0f);
    rd(8'h0d, 8'h06);
    rd(8'h0d, 8'h06);
    chk("ovf_irq", 10'(overflow_irq), 10'h001);
    wrd(8'h0d, 8'h18, 8'h1c);
    chk("ovf_irq", 10'(overflow_irq), 10'h000);
    // One timebase tick ends the lingering flag.
    wr(8'h0d, 8'h08);
    lite_timebase_clock <= 1'b1;
    repeat (8) @(posedge aclk);
    lite_timebase_clock <= 1'b0;
    rd(8'h0d, 8'h08);
    // Compare mode after a second reset.
    do_reset();
    wr(8'h18, 8'h40);
    wr(8'h0d, 8'h11);
    repeat (100) @(posedge aclk);
    chk("cmp_irq", 10'(compare_irq), 10'h001);
    wr(8'h0d, 8'h10);
    // The request flop follows the enable one cycle later.
    @(posedge aclk);
    chk("cmp_irq", 10'(compare_irq), 10'h000);
    rd(8'h13, 8'h01);
    rd(8'h13, 8'h00);
    wr(8'h17, 8'h00);
    repeat (4200) @(posedge aclk);
    rd(8'h13, 8'h00);
    wr(8'h18, 8'h40);
    repeat (4200) @(posedge aclk);
    rd(8'h13, 8'h01);
    // Pulse mode with period 16 and duty ff4.
    wr(8'h10, 8'h0f);
    wr(8'h11, 8'hf0);
    wr(8'h17, 8'h0f);
    wr(8'h18, 8'hf4);
    wr(8'h12, 8'h01);
    repeat (4200) @(posedge aclk);
    chk("pin_en", 10'(output_pin_enable), 10'h001);
    hi_count(n);
    // High from the reload count through the match count: 5 of 16.
    chk("duty", 10'(n), 10'h00a);
    wr(8'h13, 8'h02);
    hi_count(m);
    chk("invert", 10'(m), 10'(32 - n));
    wr(8'h12, 8'h00);
    hi_count(m);
    chk("pin_off", 10'(m), 10'h000);
    end_sim();
  end
endmodule

// ### verilog/arpwm_pkg.sv
package arpwm_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_TIMER_CTRL_STATUS = 8'h0d;
  localparam logic [7:0] IDX_COUNTER_HIGH = 8'h0e;
  localparam logic [7:0] IDX_COUNTER_LOW = 8'h0f;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h11;
  localparam logic [7:0] IDX_OUTPUT_CONTROL = 8'h12;
  localparam logic [7:0] IDX_CHANNEL_CTRL_STATUS = 8'h13;
  localparam logic [7:0] IDX_DUTY_HIGH = 8'h17;
  localparam logic [7:0] IDX_DUTY_LOW = 8'h18;

  // Field positions.
  localparam int CKSEL_LSB = 3;
  localparam int OVF_BIT = 2;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 1;
  localparam int COMPARE_IRQ_ENABLE_BIT = 0;
  localparam int INVERT_BIT = 1;
  localparam int CMPF_BIT = 0;
  localparam int OE_BIT = 0;

  // Counter width and overflow point.
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Counter clock selection codes.
  typedef enum logic [1:0] {
    CK_OFF = 2'h0,
    CK_LITE = 2'h1,
    CK_CPU = 2'h2,
    CK_RSVD = 2'h3
  } cksel_t;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/autoreload_pwm_timer.sv
`timescale 1ns/1ns
// Function
// - Clock select: off, lite timebase, cpu, reserved
// - Overflow flag set on FFF to reload
// - Reading control/status clears overflow; writes ignored
// - Overflow flag lingers one counter tick after clear
// - Overflow interrupt enable gates overflow request
// - Compare interrupt enable gates compare request
// - Read-only counter increments each selected tick
// - Overflow reloads counter from reload value
// - Writable reload value sets output period
// - Output enable picks duty or compare meaning
// - Polarity bit inverts pulse output
// - Match sets compare flag; read clears it
// - Output enable hands pin to pulse output
// - Overflow loads shadow, output high; match low
// - High duty write locks compare until low
// - Compare mode uses duty directly, nonzero only
// - Shadow copied each overflow, used in PWM
module autoreload_pwm_timer
  import arpwm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Lite timer millisecond timebase, asynchronous level.
  input wire logic lite_timebase_clock,
  // Pin and interrupt requests.
  output logic pulse_output,
  output logic output_pin_enable,
  output logic overflow_irq,
  output logic compare_irq
);

  // Control and data state.
  logic [1:0] cksel_q, cksel_d;
  logic overflow_irq_enable_q, overflow_irq_enable_d;
  logic compare_irq_enable_q, compare_irq_enable_d;
  logic ovf_q, ovf_d;
  logic ovf_clr_pend_q, ovf_clr_pend_d;
  logic cmpf_q, cmpf_d;
  logic invert_q, invert_d;
  logic oe_q, oe_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] reload_q, reload_d;
  logic [CNT_W-1:0] duty_q, duty_d;
  logic [CNT_W-1:0] shadow_q, shadow_d;
  logic cmp_lock_q, cmp_lock_d;
  logic wave_q, wave_d;
  logic pin_q, pin_d;
  logic oe_pin_q, oe_pin_d;
  logic ovf_irq_q, ovf_irq_d;
  logic cmp_irq_q, cmp_irq_d;

  // Bus state.
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  logic lite_tick;
  logic tick;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic rd_hit;
  logic wr_hit;
  logic at_max;
  logic [CNT_W-1:0] cmp_ref;
  logic match;

  // Timebase from the lite timer crosses into aclk.
  tick_sync u_lite_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(lite_timebase_clock),
    .rise_pulse(lite_tick)
  );

  // Counter clock enable; reserved and off codes stop it.
  always_comb begin
    case (cksel_t'(cksel_q))
      CK_LITE: tick = lite_tick;
      CK_CPU: tick = 1'b1;
      CK_OFF: tick = 1'b0;
      CK_RSVD: tick = 1'b0;
      default: tick = 1'b0;
    endcase
  end

  // Bus handshakes and word index.
  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  assign rd_fire = s_axi_arvalid & ~rvalid_q;
  assign wr_idx = 8'(awaddr_q >> 2);
  assign rd_idx = 8'(s_axi_araddr >> 2);
  assign wbyte = wdata_q[7:0];
  assign at_max = (cnt_q == CNT_MAX);
  // PWM uses the shadow, compare mode the live duty value.
  assign cmp_ref = oe_q ? shadow_q : duty_q;
  assign match = tick & ~cmp_lock_q & (cnt_q == cmp_ref)
    & (oe_q | (duty_q != CNT_ZERO));

  // Read multiplexer; reserved bits read zero.
  always_comb begin
    rd_hit = 1'b1;
    rbyte = BYTE_ZERO;
    case (rd_idx)
      IDX_TIMER_CTRL_STATUS: begin
        rbyte[CKSEL_LSB+:2] = cksel_q;
        rbyte[OVF_BIT] = ovf_q;
        rbyte[OVERFLOW_IRQ_ENABLE_BIT] = overflow_irq_enable_q;
        rbyte[COMPARE_IRQ_ENABLE_BIT] = compare_irq_enable_q;
      end
      IDX_COUNTER_HIGH: rbyte[3:0] = cnt_q[11:8];
      IDX_COUNTER_LOW: rbyte = cnt_q[7:0];
      IDX_RELOAD_HIGH: rbyte[3:0] = reload_q[11:8];
      IDX_RELOAD_LOW: rbyte = reload_q[7:0];
      IDX_OUTPUT_CONTROL: rbyte[OE_BIT] = oe_q;
      IDX_CHANNEL_CTRL_STATUS: begin
        rbyte[INVERT_BIT] = invert_q;
        rbyte[CMPF_BIT] = cmpf_q;
      end
      IDX_DUTY_HIGH: rbyte[3:0] = duty_q[11:8];
      IDX_DUTY_LOW: rbyte = duty_q[7:0];
      default: rd_hit = 1'b0;
    endcase
  end

  // Write decode hit test.
  always_comb begin
    case (wr_idx)
      IDX_TIMER_CTRL_STATUS, IDX_RELOAD_HIGH, IDX_RELOAD_LOW,
      IDX_OUTPUT_CONTROL, IDX_CHANNEL_CTRL_STATUS, IDX_DUTY_HIGH,
      IDX_DUTY_LOW: wr_hit = 1'b1;
      IDX_COUNTER_HIGH, IDX_COUNTER_LOW: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // AXI4-Lite slave next state.
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && !aw_got_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wlane_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rbyte};
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Timer, flags, registers and output next state.
  always_comb begin
    cksel_d = cksel_q;
    overflow_irq_enable_d = overflow_irq_enable_q;
    compare_irq_enable_d = compare_irq_enable_q;
    ovf_d = ovf_q;
    ovf_clr_pend_d = ovf_clr_pend_q;
    cmpf_d = cmpf_q;
    invert_d = invert_q;
    oe_d = oe_q;
    cnt_d = cnt_q;
    reload_d = reload_q;
    duty_d = duty_q;
    shadow_d = shadow_q;
    cmp_lock_d = cmp_lock_q;
    wave_d = wave_q;
    // Software writes; only the low byte lane carries data.
    if (wr_fire && wlane_q) begin
      case (wr_idx)
        IDX_TIMER_CTRL_STATUS: begin
          cksel_d = wbyte[CKSEL_LSB+:2];
          overflow_irq_enable_d = wbyte[OVERFLOW_IRQ_ENABLE_BIT];
          compare_irq_enable_d = wbyte[COMPARE_IRQ_ENABLE_BIT];
        end
        IDX_RELOAD_HIGH: reload_d[11:8] = wbyte[3:0];
        IDX_RELOAD_LOW: reload_d[7:0] = wbyte;
        IDX_OUTPUT_CONTROL: oe_d = wbyte[OE_BIT];
        IDX_CHANNEL_CTRL_STATUS: invert_d = wbyte[INVERT_BIT];
        IDX_DUTY_HIGH: begin
          duty_d[11:8] = wbyte[3:0];
          cmp_lock_d = 1'b1;
        end
        IDX_DUTY_LOW: begin
          duty_d[7:0] = wbyte;
          cmp_lock_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Read of control/status arms the delayed overflow clear.
    if (rd_fire && rd_idx == IDX_TIMER_CTRL_STATUS && ovf_q) begin
      ovf_clr_pend_d = 1'b1;
    end
    if (rd_fire && rd_idx == IDX_CHANNEL_CTRL_STATUS) begin
      cmpf_d = 1'b0;
    end
    // Flag falls one counter tick after the clearing read.
    if (tick && ovf_clr_pend_q) begin
      ovf_d = 1'b0;
      ovf_clr_pend_d = 1'b0;
    end
    if (tick) begin
      if (at_max) begin
        cnt_d = reload_q;
        ovf_d = 1'b1;
        ovf_clr_pend_d = 1'b0;
        shadow_d = duty_q;
        wave_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 12'h001;
      end
    end
    // Match sets the flag and, in PWM mode, lowers the wave; set beats clear.
    if (match) begin
      cmpf_d = 1'b1;
      if (oe_q) begin
        wave_d = 1'b0;
      end
    end
  end

  // Output pin and interrupt requests.
  always_comb begin
    pin_d = oe_q & (wave_q ^ invert_q);
    oe_pin_d = oe_q;
    ovf_irq_d = ovf_q & overflow_irq_enable_q;
    cmp_irq_d = cmpf_q & compare_irq_enable_q;
  end

  // All registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cksel_q <= 2'h0;
      overflow_irq_enable_q <= 1'b0;
      compare_irq_enable_q <= 1'b0;
      ovf_q <= 1'b0;
      ovf_clr_pend_q <= 1'b0;
      cmpf_q <= 1'b0;
      invert_q <= 1'b0;
      oe_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      reload_q <= CNT_ZERO;
      duty_q <= CNT_ZERO;
      shadow_q <= CNT_ZERO;
      cmp_lock_q <= 1'b0;
      wave_q <= 1'b0;
      pin_q <= 1'b0;
      oe_pin_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      cmp_irq_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= WORD_ZERO;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= WORD_ZERO;
      rresp_q <= RESP_OKAY;
    end else begin
      cksel_q <= cksel_d;
      overflow_irq_enable_q <= overflow_irq_enable_d;
      compare_irq_enable_q <= compare_irq_enable_d;
      ovf_q <= ovf_d;
      ovf_clr_pend_q <= ovf_clr_pend_d;
      cmpf_q <= cmpf_d;
      invert_q <= invert_d;
      oe_q <= oe_d;
      cnt_q <= cnt_d;
      reload_q <= reload_d;
      duty_q <= duty_d;
      shadow_q <= shadow_d;
      cmp_lock_q <= cmp_lock_d;
      wave_q <= wave_d;
      pin_q <= pin_d;
      oe_pin_q <= oe_pin_d;
      ovf_irq_q <= ovf_irq_d;
      cmp_irq_q <= cmp_irq_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Ports straight from flops.
  assign s_axi_awready = ~aw_got_q;
  assign s_axi_wready = ~w_got_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pulse_output = pin_q;
  assign output_pin_enable = oe_pin_q;
  assign overflow_irq = ovf_irq_q;
  assign compare_irq = cmp_irq_q;

endmodule

// ### verilog/tick_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser with rising-edge pulse out.
module tick_sync (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level in, one-cycle pulse out.
  input wire logic async_in,
  output logic rise_pulse
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  // Next values: first flop feeds only the second.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // Registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // Edge from the second and third stages only.
  assign rise_pulse = sync_q & ~last_q;

endmodule
